// ===== hdl/test_pattern_pkg.sv
// Shared constants for the converter output test pattern generator
`default_nettype none
package test_pattern_pkg;
   // Register map offsets
   localparam logic [15:0] ADDR_SOFT_RESET   = 16'h0000;
   localparam logic [15:0] ADDR_PATH0_TEST   = 16'h0327;
   localparam logic [15:0] ADDR_PATH1_TEST   = 16'h0347;
   localparam logic [15:0] ADDR_PATH2_TEST   = 16'h0367;
   localparam logic [15:0] ADDR_PATH3_TEST   = 16'h0387;
   localparam logic [15:0] ADDR_PATTERN_SEL  = 16'h0550;
   localparam logic [15:0] ADDR_USER_BYTE0   = 16'h0551;
   localparam logic [15:0] ADDR_USER_BYTE7   = 16'h0558;
   localparam logic [15:0] ADDR_TRANSPORT    = 16'h0571;
   localparam logic [15:0] ADDR_LINK_SEL     = 16'h0573;
   localparam logic [15:0] ADDR_LINK_CFG     = 16'h0574;

   // Field positions
   localparam int PSEL_RESET_LONG_BIT  = 4;
   localparam int PSEL_RESET_SHORT_BIT = 5;
   localparam int PSEL_SINGLE_BIT      = 7;
   localparam int PATH_I_EN_BIT        = 0;
   localparam int PATH_Q_EN_BIT        = 2;
   localparam int TRANSPORT_EN_BIT     = 5;

   // Reset values and codes
   localparam logic [7:0] REG_RESET_VALUE = 8'h00;
   localparam logic [7:0] SOFT_RESET_CODE = 8'h81;

   // Pattern select codes
   localparam logic [3:0] MODE_NORMAL   = 4'h0;
   localparam logic [3:0] MODE_MIDSCALE = 4'h1;
   localparam logic [3:0] MODE_POS_FS   = 4'h2;
   localparam logic [3:0] MODE_NEG_FS   = 4'h3;
   localparam logic [3:0] MODE_CHECKER  = 4'h4;
   localparam logic [3:0] MODE_PN_LONG  = 4'h5;
   localparam logic [3:0] MODE_PN_SHORT = 4'h6;
   localparam logic [3:0] MODE_TOGGLE   = 4'h7;
   localparam logic [3:0] MODE_USER     = 4'h8;
   localparam logic [3:0] MODE_RAMP     = 4'hf;

   // Pattern words
   localparam int          SAMPLE_W      = 14;
   localparam logic [13:0] WORD_MIDSCALE = 14'h0000;
   localparam logic [13:0] WORD_POS_FS   = 14'h1fff;
   localparam logic [13:0] WORD_NEG_FS   = 14'h2000;
   localparam logic [13:0] WORD_CHECK_0  = 14'h1555;
   localparam logic [13:0] WORD_CHECK_1  = 14'h2aaa;
   localparam logic [13:0] WORD_ZEROS    = 14'h0000;
   localparam logic [13:0] WORD_ONES     = 14'h3fff;

   // Pseudorandom generators
   localparam int          PN_LONG_LEN   = 23;
   localparam int          PN_LONG_TAP   = 18;
   localparam logic [22:0] PN_LONG_SEED  = 23'h003aff;
   localparam int          PN_SHORT_LEN  = 9;
   localparam int          PN_SHORT_TAP  = 5;
   localparam logic [8:0]  PN_SHORT_SEED = 9'h092;
endpackage
`default_nettype wire

// ===== hdl/adc_output_test_pattern_gen.sv
// Converter output test pattern generator with its register bank
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Pseudorandom stream generator, fourteen serial bits per sample, first bit in MSB
module pn_stream_gen #(
   parameter int         LEN  = 9,
   parameter int         TAP  = 5,
   parameter logic [LEN-1:0] SEED = '0
) (
   input  wire logic            mclk,
   input  wire logic            reset,
   input  wire logic            restart,
   input  wire logic            advance,
   output logic [13:0]          sample
);
   logic [LEN-1:0]  state_r;
   logic [LEN-1:0]  base;
   logic [LEN+13:0] ext;

   // Extend the stream: bit k follows from bits k-LEN and k-TAP
   always_comb begin
      base = restart ? SEED : state_r;
      ext  = '0;
      // Two loops so no select ever reaches below bit zero
      for (int k = 0; k < LEN; k++) begin
         ext[k] = base[k];
      end
      for (int k = LEN; k < LEN + 14; k++) begin
         ext[k] = ext[k-LEN] ^ ext[k-TAP];
      end
      for (int j = 0; j < 14; j++) begin
         sample[13-j] = ext[j];
      end
   end

   // Consume fourteen bits per sample; restart makes the seed the base of the current sample
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         state_r <= SEED;
      end else if (advance) begin
         state_r <= ext[LEN+13:14];
      end else if (restart) begin
         state_r <= SEED;
      end
   end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Top level
module adc_output_test_pattern_gen (
   input  wire logic        mclk,
   input  wire logic        reset,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [15:0] reg_addr,
   input  wire logic [7:0]  reg_wdata,
   output logic [7:0]       reg_rdata,
   input  wire logic [13:0] adc_a,
   input  wire logic [13:0] adc_b,
   output logic [13:0]      fmt_a,
   output logic [13:0]      fmt_b,
   output logic             fmt_bypass,
   output logic             test_active,
   output logic [13:0]      path_i_data,
   output logic [13:0]      path_q_data,
   output logic [3:0]       path_i_test_en,
   output logic [3:0]       path_q_test_en,
   output logic [3:0]       link_pattern_sel,
   output logic [1:0]       link_inject_point,
   output logic [7:0]       link_pattern_cfg,
   output logic             transport_test_en,
   output logic [13:0]      framer_sample_a,
   output logic [13:0]      framer_sample_b,
   output logic             soft_reset_pulse
);
   logic [7:0]  pattern_sel_r;
   logic [7:0]  user_byte_r [8];
   logic [3:0]  path_i_en_r;
   logic [3:0]  path_q_en_r;
   logic [7:0]  transport_r;
   logic [7:0]  link_sel_r;
   logic [7:0]  link_cfg_r;
   logic        soft_reset_r;
   logic [3:0]  mode;
   logic [3:0]  prev_mode_r;
   logic        newly;
   logic        phase_r;
   logic        phase_cur;
   logic [13:0] ramp_r;
   logic [13:0] ramp_cur;
   logic [1:0]  user_idx_r;
   logic [1:0]  user_idx_cur;
   logic        user_done_r;
   logic        user_done_cur;
   logic [13:0] pn_long_sample;
   logic [13:0] pn_short_sample;
   logic [13:0] pat;
   logic        pat_active;
   logic        pat_bypass;
   logic [15:0] user_word;

   ////////////////////////////////////////////////////////////////////////////
   // Register writes; soft reset returns every register to its reset value
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         soft_reset_r <= 1'b0;
      end else begin
         soft_reset_r <= reg_wr && !soft_reset_r && reg_addr == test_pattern_pkg::ADDR_SOFT_RESET
                         && reg_wdata == test_pattern_pkg::SOFT_RESET_CODE;
      end
   end

   // Bank of control registers; a soft reset beats a write in the same cycle
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         pattern_sel_r <= test_pattern_pkg::REG_RESET_VALUE;
         path_i_en_r   <= '0;
         path_q_en_r   <= '0;
         transport_r   <= test_pattern_pkg::REG_RESET_VALUE;
         link_sel_r    <= test_pattern_pkg::REG_RESET_VALUE;
         link_cfg_r    <= test_pattern_pkg::REG_RESET_VALUE;
         for (int i = 0; i < 8; i++) begin
            user_byte_r[i] <= test_pattern_pkg::REG_RESET_VALUE;
         end
      end else if (soft_reset_r) begin
         pattern_sel_r <= test_pattern_pkg::REG_RESET_VALUE;
         path_i_en_r   <= '0;
         path_q_en_r   <= '0;
         transport_r   <= test_pattern_pkg::REG_RESET_VALUE;
         link_sel_r    <= test_pattern_pkg::REG_RESET_VALUE;
         link_cfg_r    <= test_pattern_pkg::REG_RESET_VALUE;
         for (int i = 0; i < 8; i++) begin
            user_byte_r[i] <= test_pattern_pkg::REG_RESET_VALUE;
         end
      end else if (reg_wr) begin
         unique case (reg_addr)
            test_pattern_pkg::ADDR_PATTERN_SEL: pattern_sel_r <= reg_wdata;
            test_pattern_pkg::ADDR_PATH0_TEST: begin
               path_i_en_r[0] <= reg_wdata[test_pattern_pkg::PATH_I_EN_BIT];
               path_q_en_r[0] <= reg_wdata[test_pattern_pkg::PATH_Q_EN_BIT];
            end
            test_pattern_pkg::ADDR_PATH1_TEST: begin
               path_i_en_r[1] <= reg_wdata[test_pattern_pkg::PATH_I_EN_BIT];
               path_q_en_r[1] <= reg_wdata[test_pattern_pkg::PATH_Q_EN_BIT];
            end
            test_pattern_pkg::ADDR_PATH2_TEST: begin
               path_i_en_r[2] <= reg_wdata[test_pattern_pkg::PATH_I_EN_BIT];
               path_q_en_r[2] <= reg_wdata[test_pattern_pkg::PATH_Q_EN_BIT];
            end
            // Fourth path has no quadrature enable at all
            test_pattern_pkg::ADDR_PATH3_TEST: path_i_en_r[3] <= reg_wdata[test_pattern_pkg::PATH_I_EN_BIT];
            test_pattern_pkg::ADDR_TRANSPORT:  transport_r <= reg_wdata;
            test_pattern_pkg::ADDR_LINK_SEL:   link_sel_r  <= reg_wdata;
            test_pattern_pkg::ADDR_LINK_CFG:   link_cfg_r  <= reg_wdata;
            default: begin
               if (reg_addr >= test_pattern_pkg::ADDR_USER_BYTE0 && reg_addr <= test_pattern_pkg::ADDR_USER_BYTE7) begin
                  user_byte_r[3'(reg_addr - test_pattern_pkg::ADDR_USER_BYTE0)] <= reg_wdata;
               end
            end
         endcase
      end
   end

   // Read port; unmapped addresses read zero, address zero shows a pending soft reset
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         reg_rdata <= '0;
      end else if (reg_rd) begin
         unique case (reg_addr)
            test_pattern_pkg::ADDR_SOFT_RESET:  reg_rdata <= soft_reset_r ? test_pattern_pkg::SOFT_RESET_CODE : 8'h00;
            test_pattern_pkg::ADDR_PATTERN_SEL: reg_rdata <= pattern_sel_r;
            test_pattern_pkg::ADDR_PATH0_TEST:  reg_rdata <= {5'h00, path_q_en_r[0], 1'b0, path_i_en_r[0]};
            test_pattern_pkg::ADDR_PATH1_TEST:  reg_rdata <= {5'h00, path_q_en_r[1], 1'b0, path_i_en_r[1]};
            test_pattern_pkg::ADDR_PATH2_TEST:  reg_rdata <= {5'h00, path_q_en_r[2], 1'b0, path_i_en_r[2]};
            test_pattern_pkg::ADDR_PATH3_TEST:  reg_rdata <= {7'h00, path_i_en_r[3]};
            test_pattern_pkg::ADDR_TRANSPORT:   reg_rdata <= transport_r;
            test_pattern_pkg::ADDR_LINK_SEL:    reg_rdata <= link_sel_r;
            test_pattern_pkg::ADDR_LINK_CFG:    reg_rdata <= link_cfg_r;
            default: begin
               if (reg_addr >= test_pattern_pkg::ADDR_USER_BYTE0 && reg_addr <= test_pattern_pkg::ADDR_USER_BYTE7) begin
                  reg_rdata <= user_byte_r[3'(reg_addr - test_pattern_pkg::ADDR_USER_BYTE0)];
               end else begin
                  reg_rdata <= 8'h00;
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Mode tracking; a freshly selected mode starts its sequence from the top
   assign mode  = pattern_sel_r[3:0];
   assign newly = mode != prev_mode_r;

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         prev_mode_r <= test_pattern_pkg::MODE_NORMAL;
      end else begin
         prev_mode_r <= mode;
      end
   end

   // Shared phase for checkerboard and word toggle
   assign phase_cur = newly ? 1'b0 : phase_r;

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         phase_r <= 1'b0;
      end else begin
         phase_r <= !phase_cur;
      end
   end

   // Ramp counter, wraps by width
   assign ramp_cur = newly ? 14'h0000 : ramp_r;

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         ramp_r <= 14'h0000;
      end else begin
         ramp_r <= 14'(ramp_cur + 14'h0001);
      end
   end

   // User pattern sequencer
   assign user_idx_cur  = newly ? 2'h0 : user_idx_r;
   assign user_done_cur = newly ? 1'b0 : user_done_r;
   assign user_word     = {user_byte_r[{user_idx_cur, 1'b1}], user_byte_r[{user_idx_cur, 1'b0}]};

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         user_idx_r  <= 2'h0;
         user_done_r <= 1'b0;
      end else begin
         user_idx_r  <= 2'(user_idx_cur + 2'h1);
         user_done_r <= user_done_cur || (user_idx_cur == 2'h3 && pattern_sel_r[test_pattern_pkg::PSEL_SINGLE_BIT]);
      end
   end

   // Pseudorandom generators only move while their own mode runs
   pn_stream_gen #(
      .LEN  (test_pattern_pkg::PN_LONG_LEN),
      .TAP  (test_pattern_pkg::PN_LONG_TAP),
      .SEED (test_pattern_pkg::PN_LONG_SEED)
   ) u_pn_long (
      .mclk    (mclk),
      .reset   (reset),
      .restart (pattern_sel_r[test_pattern_pkg::PSEL_RESET_LONG_BIT] || (newly && mode == test_pattern_pkg::MODE_PN_LONG)),
      .advance (mode == test_pattern_pkg::MODE_PN_LONG),
      .sample  (pn_long_sample)
   );

   pn_stream_gen #(
      .LEN  (test_pattern_pkg::PN_SHORT_LEN),
      .TAP  (test_pattern_pkg::PN_SHORT_TAP),
      .SEED (test_pattern_pkg::PN_SHORT_SEED)
   ) u_pn_short (
      .mclk    (mclk),
      .reset   (reset),
      .restart (pattern_sel_r[test_pattern_pkg::PSEL_RESET_SHORT_BIT] || (newly && mode == test_pattern_pkg::MODE_PN_SHORT)),
      .advance (mode == test_pattern_pkg::MODE_PN_SHORT),
      .sample  (pn_short_sample)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Pattern decode; unlisted codes behave as normal data
   always_comb begin
      pat        = test_pattern_pkg::WORD_ZEROS;
      pat_active = 1'b1;
      pat_bypass = 1'b1;
      unique case (mode)
         test_pattern_pkg::MODE_MIDSCALE: begin
            pat        = test_pattern_pkg::WORD_MIDSCALE;
            pat_bypass = 1'b0;
         end
         test_pattern_pkg::MODE_POS_FS: begin
            pat        = test_pattern_pkg::WORD_POS_FS;
            pat_bypass = 1'b0;
         end
         test_pattern_pkg::MODE_NEG_FS: begin
            pat        = test_pattern_pkg::WORD_NEG_FS;
            pat_bypass = 1'b0;
         end
         test_pattern_pkg::MODE_CHECKER:  pat = phase_cur ? test_pattern_pkg::WORD_CHECK_1 : test_pattern_pkg::WORD_CHECK_0;
         test_pattern_pkg::MODE_PN_LONG:  pat = pn_long_sample;
         test_pattern_pkg::MODE_PN_SHORT: pat = pn_short_sample;
         test_pattern_pkg::MODE_TOGGLE:   pat = phase_cur ? test_pattern_pkg::WORD_ONES : test_pattern_pkg::WORD_ZEROS;
         test_pattern_pkg::MODE_USER:     pat = user_done_cur ? test_pattern_pkg::WORD_ZEROS : user_word[15:2];
         test_pattern_pkg::MODE_RAMP:     pat = ramp_cur;
         default: begin
            pat_active = 1'b0;
            pat_bypass = 1'b0;
         end
      endcase
   end

   // Output registers; core samples are cut off while a pattern runs
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         fmt_a       <= '0;
         fmt_b       <= '0;
         fmt_bypass  <= 1'b0;
         test_active <= 1'b0;
         path_i_data <= '0;
         path_q_data <= '0;
      end else begin
         fmt_a       <= pat_active ? pat : adc_a;
         fmt_b       <= pat_active ? pat : adc_b;
         fmt_bypass  <= pat_bypass;
         test_active <= pat_active;
         path_i_data <= pat;
         path_q_data <= pat;
      end
   end

   // Per-path enables and link controls
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         path_i_test_en    <= '0;
         path_q_test_en    <= '0;
         link_pattern_sel  <= '0;
         link_inject_point <= '0;
         link_pattern_cfg  <= '0;
         transport_test_en <= 1'b0;
         framer_sample_a   <= '0;
         framer_sample_b   <= '0;
         soft_reset_pulse  <= 1'b0;
      end else begin
         path_i_test_en    <= path_i_en_r & {4{pat_active}};
         path_q_test_en    <= {1'b0, path_q_en_r[2:0] & {3{pat_active}}};
         link_pattern_sel  <= link_sel_r[3:0];
         link_inject_point <= link_sel_r[5:4];
         link_pattern_cfg  <= link_cfg_r;
         transport_test_en <= transport_r[test_pattern_pkg::TRANSPORT_EN_BIT];
         framer_sample_a   <= adc_a;
         framer_sample_b   <= adc_b;
         soft_reset_pulse  <= soft_reset_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);

   sequence long_start;
      (mode == test_pattern_pkg::MODE_PN_LONG && newly) ##1
      (mode == test_pattern_pkg::MODE_PN_LONG && !pattern_sel_r[test_pattern_pkg::PSEL_RESET_LONG_BIT]);
   endsequence

   sequence short_start;
      (mode == test_pattern_pkg::MODE_PN_SHORT && newly) ##1
      (mode == test_pattern_pkg::MODE_PN_SHORT && !pattern_sel_r[test_pattern_pkg::PSEL_RESET_SHORT_BIT]);
   endsequence

   sequence single_user_run;
      (mode == test_pattern_pkg::MODE_USER && newly && pattern_sel_r[test_pattern_pkg::PSEL_SINGLE_BIT]) ##1
      (mode == test_pattern_pkg::MODE_USER && pattern_sel_r[test_pattern_pkg::PSEL_SINGLE_BIT])[*4];
   endsequence

   chk_pos_full_scale: assert property (mode == test_pattern_pkg::MODE_POS_FS |=> fmt_a == 14'h1fff && fmt_b == 14'h1fff)
      else $error("positive full scale word wrong");
   chk_normal_passthru: assert property (mode == test_pattern_pkg::MODE_NORMAL |=> fmt_a == $past(adc_a) && !test_active)
      else $error("normal mode does not pass core samples");
   chk_fixed_formatted: assert property (mode == test_pattern_pkg::MODE_NEG_FS |=> !fmt_bypass && fmt_a == 14'h2000)
      else $error("fixed level not routed through formatting");
   chk_pn_reset_bit: assert property (pattern_sel_r[test_pattern_pkg::PSEL_RESET_LONG_BIT] && mode == test_pattern_pkg::MODE_PN_LONG |=> fmt_a == 14'h3fd7)
      else $error("long sequence not at seed while reset bit set");
   chk_analog_ignored: assert property (mode == test_pattern_pkg::MODE_MIDSCALE |=> fmt_a == 14'h0000 && test_active)
      else $error("analog input leaks into midscale pattern");
   chk_path_iq_map: assert property (test_active |-> path_i_data == fmt_a && path_q_data == fmt_b)
      else $error("path data does not follow channel patterns");
   chk_path3_no_q: assert property (path_q_test_en[3] == 1'b0)
      else $error("fourth path quadrature carries a pattern");
   chk_path3_i_enable: assert property (reg_wr && !soft_reset_r && reg_addr == test_pattern_pkg::ADDR_PATH3_TEST ##1 pat_active
      |=> path_i_test_en[3] == $past(reg_wdata[0], 2))
      else $error("fourth path in-phase enable not applied");
   chk_checker_first: assert property (mode == test_pattern_pkg::MODE_CHECKER && newly ##1 mode == test_pattern_pkg::MODE_CHECKER
      |-> fmt_a == 14'h1555 ##1 fmt_a == 14'h2aaa)
      else $error("checkerboard order wrong");
   chk_toggle_first: assert property (mode == test_pattern_pkg::MODE_TOGGLE && newly ##1 mode == test_pattern_pkg::MODE_TOGGLE
      |-> fmt_a == 14'h0000 ##1 fmt_a == 14'h3fff)
      else $error("word toggle order wrong");
   chk_pn_long_seq: assert property (long_start |-> fmt_a == 14'h3fd7 ##1 fmt_a == 14'h0002)
      else $error("long sequence start wrong");
   chk_pn_short_seq: assert property (short_start |-> fmt_a == 14'h125b ##1 fmt_a == 14'h3c9a)
      else $error("short sequence start wrong");
   chk_user_single_zero: assert property (single_user_run |=> fmt_a == 14'h0000)
      else $error("single user run does not end in zeros");
   chk_link_select: assert property (reg_wr && !soft_reset_r && reg_addr == test_pattern_pkg::ADDR_LINK_SEL
      ##1 !soft_reset_r |=> link_pattern_sel == $past(reg_wdata[3:0], 2) && link_inject_point == $past(reg_wdata[5:4], 2))
      else $error("link test select not applied");
   chk_soft_reset_clear: assert property (soft_reset_r |-> !$past(soft_reset_r) ##1 (link_sel_r == 8'h00 && soft_reset_pulse && !soft_reset_r))
      else $error("soft reset did not clear itself and the link select");
   chk_transport_raw: assert property (transport_r[5] |=> transport_test_en && framer_sample_a == $past(adc_a))
      else $error("transport sample test does not carry raw samples");
   chk_ramp_step: assert property (mode == test_pattern_pkg::MODE_RAMP && !newly |=> fmt_a == 14'($past(fmt_a) + 14'h0001))
      else $error("ramp did not step by one");
   chk_ramp_restart: assert property (mode == test_pattern_pkg::MODE_RAMP && newly |=> fmt_a == 14'h0000)
      else $error("ramp did not restart at zero");
endmodule
`default_nettype wire

// ===== verification/fmt_framer_model.sv
// Far-side model of the output formatter and framer sample inputs
`default_nettype none
module fmt_framer_model (
   input  wire logic        mclk,
   input  wire logic [13:0] fmt_a,
   input  wire logic [13:0] framer_sample_a,
   output logic [13:0]      fmt_seen,
   output logic [13:0]      framer_seen
);
   timeunit 1ns;
   timeprecision 1ps;
   // Takes one word per encode clock; no backpressure exists on this path
   always_ff @(posedge mclk) begin
      fmt_seen    <= fmt_a;
      framer_seen <= framer_sample_a;
   end
endmodule
`default_nettype wire

// ===== verification/tb_adc_output_test_pattern_gen.sv
// Self-checking bench for the converter test pattern generator
`default_nettype none
module tb_adc_output_test_pattern_gen;
   timeunit 1ns;
   timeprecision 1ps;
   logic        mclk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [15:0] reg_addr = 16'h0000;
   logic [7:0]  reg_wdata = 8'h00, reg_rdata, link_pattern_cfg, d;
   logic [13:0] adc_a = 14'h0000, adc_b = 14'h0000, fmt_a, fmt_b, path_i_data, path_q_data;
   logic [13:0] framer_sample_a, framer_sample_b, fmt_seen, framer_seen, last_a;
   logic        fmt_bypass, test_active, transport_test_en, soft_reset_pulse;
   logic [3:0]  path_i_test_en, path_q_test_en, link_pattern_sel;
   logic [1:0]  link_inject_point;
   logic [15:0] up [4];
   logic [3:0]  modes [8] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'hf};
   int          err_total = 0, checks_done = 0, cyc = 0;
   adc_output_test_pattern_gen adc_output_test_pattern_gen_inst (
      .mclk              (mclk),
      .reset             (reset),
      .reg_wr            (reg_wr),
      .reg_rd            (reg_rd),
      .reg_addr          (reg_addr),
      .reg_wdata         (reg_wdata),
      .reg_rdata         (reg_rdata),
      .adc_a             (adc_a),
      .adc_b             (adc_b),
      .fmt_a             (fmt_a),
      .fmt_b             (fmt_b),
      .fmt_bypass        (fmt_bypass),
      .test_active       (test_active),
      .path_i_data       (path_i_data),
      .path_q_data       (path_q_data),
      .path_i_test_en    (path_i_test_en),
      .path_q_test_en    (path_q_test_en),
      .link_pattern_sel  (link_pattern_sel),
      .link_inject_point (link_inject_point),
      .link_pattern_cfg  (link_pattern_cfg),
      .transport_test_en (transport_test_en),
      .framer_sample_a   (framer_sample_a),
      .framer_sample_b   (framer_sample_b),
      .soft_reset_pulse  (soft_reset_pulse)
   );
   fmt_framer_model fmt_framer_model_inst (
      .mclk            (mclk),
      .fmt_a           (fmt_a),
      .framer_sample_a (framer_sample_a),
      .fmt_seen        (fmt_seen),
      .framer_seen     (framer_seen)
   );
   // Clock, cycle ceiling and random core samples
   always #4 mclk = ~mclk;
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 3000) begin
         err_total++;
         close_out();
      end
   end
   // Non-blocking so checks at the same instant still see the sampled value
   always @(posedge mclk) begin
      #1;
      adc_a <= 14'($urandom);
      adc_b <= 14'($urandom);
   end
   task automatic close_out();
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic step();
      @(posedge mclk);
      #1;
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] v);
      step();
      {reg_wr, reg_addr, reg_wdata} = {1'b1, a, v};
      step();
      reg_wr = 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      step();
      {reg_rd, reg_addr} = {1'b1, a};
      step();
      reg_rd = 1'b0;
      chk(reg_rdata, e);
   endtask
   // Expected word k of each pattern from its start
   function automatic logic [13:0] pat(input logic [3:0] m, input int k);
      case (m)
         4'h2: return 14'h1fff;
         4'h3: return 14'h2000;
         4'h4: return k[0] ? 14'h2aaa : 14'h1555;
         4'h5: return k[0] ? 14'h0002 : 14'h3fd7;
         4'h6: return k[0] ? 14'h3c9a : 14'h125b;
         4'h7: return k[0] ? 14'h3fff : 14'h0000;
         4'hf: return k[13:0];
         default: return 14'h0000;
      endcase
   endfunction
   // Main sequence
   initial begin
      void'($urandom(32'h7138d726));
      repeat (20) @(posedge mclk);
      #1 reset = 1'b0;
      rd(16'h0550, 8'h00);
      rd(16'h1234, 8'h00);
      step();
      chk(fmt_a, adc_a);
      chk(fmt_b, adc_b);
      chk(test_active, 16'h0);
      chk(framer_sample_a, adc_a);
      chk(framer_sample_b, adc_b);
      last_a = adc_a;
      step();
      chk(framer_seen, last_a);
      wr(16'h0327, 8'h05);
      wr(16'h0387, 8'h05);
      rd(16'h0387, 8'h01);
      foreach (modes[i]) begin
         wr(16'h0550, {4'h0, modes[i]});
         for (int k = 0; k < 2; k++) begin
            step();
            chk(fmt_a, pat(modes[i], k));
            chk(fmt_b, pat(modes[i], k));
            chk(fmt_bypass, 16'(modes[i] > 4'h3));
            chk(path_i_data, pat(modes[i], k));
            chk(path_q_data, pat(modes[i], k));
            if (k == 1) chk(fmt_seen, pat(modes[i], 0));
         end
      end
      chk(test_active, 16'h1);
      chk(path_i_test_en, 16'h9);
      chk(path_q_test_en, 16'h1);
      // Clearing the fourth path enable while the ramp runs; bit 2 has no effect there
      wr(16'h0387, 8'h04);
      step();
      chk(path_i_test_en, 16'h1);
      // Each reset bit parks its own generator on its first word
      for (int s = 0; s < 2; s++) begin
         wr(16'h0550, s[0] ? 8'h26 : 8'h15);
         repeat (2) begin
            step();
            chk(fmt_a, s[0] ? 16'h125b : 16'h3fd7);
         end
      end
      for (int i = 0; i < 8; i++) begin
         d = 8'($urandom);
         up[i / 2][8 * (i % 2) +: 8] = d;
         wr(16'h0551 + 16'(i), d);
      end
      for (int s = 0; s < 2; s++) begin
         wr(16'h0550, 8'h00);
         wr(16'h0550, s[0] ? 8'h88 : 8'h08);
         for (int k = 0; k < 5; k++) begin
            step();
            chk(fmt_a, (k == 4 && s == 1) ? 16'h0 : 16'(up[k % 4][15:2]));
         end
      end
      wr(16'h0573, 8'h2a);
      d = 8'($urandom);
      wr(16'h0574, d);
      wr(16'h0571, 8'h20);
      step();
      chk(link_pattern_cfg, 16'(d));
      chk(link_pattern_sel, 16'ha);
      chk(link_inject_point, 16'h2);
      chk(transport_test_en, 16'h1);
      wr(16'h0000, 8'h81);
      step();
      chk(soft_reset_pulse, 16'h1);
      step();
      chk(soft_reset_pulse, 16'h0);
      chk(link_pattern_cfg, 16'h0);
      rd(16'h0573, 8'h00);
      rd(16'h0000, 8'h00);
      close_out();
   end
endmodule
`default_nettype wire
